// File: logic/ccs_pkg.sv
/*
  Constants, register map and types for the controller status flag block.
  Assumes the including design is clocked by one system clock and that every
  user of these names refers to them through the package scope.
*/
// How it works
// - The live receive level bit follows the receive pin every clock and reads 1 after reset.
// - The last sampled receive level bit takes the pin level at each bit-sample strobe and resets to 1.
// - The receive-in-progress bit sets when a reception starts, clears when it ends, and resets to 0.
// - The transmit-in-progress bit sets when a transmission starts, clears when it completes, and resets to 0.
// - The sleep-entry flag sets only when its enable is 1 as sleep is entered, and raises the interrupt.
// - The sleep-entry flag clears on a written 1 and also by hardware when the sleep acknowledge drops.
// - Sleep is left when a start of frame is seen, and that sets the sleep-exit flag, which resets to 0.
// - A set sleep-exit flag raises the interrupt while its enable is 1, and a written 1 clears it.
// - The error flag reads 1 once an enabled error source has been active, whatever its interrupt enable, until a written 1 clears it.
// - Bits 31 to 12 and 7 to 5 are reserved and always read as zero.
// - The error flag sets only when an error source and its matching enable are both 1; a 1 clears it.
package ccs_pkg;

  // Register byte addresses.
  localparam logic [7:0] ADDR_STATUS  = 8'h00; // controller_status
  localparam logic [7:0] ADDR_IRQ_EN  = 8'h04; // interrupt enables, status layout
  localparam logic [7:0] ADDR_ERR_EN  = 8'h08; // per-source error enables

  // Field positions in controller_status and the enable register.
  localparam int BIT_LIVE_RX    = 11;
  localparam int BIT_SAMPLED_RX = 10;
  localparam int BIT_RX_BUSY    = 9;
  localparam int BIT_TX_BUSY    = 8;
  localparam int BIT_ENTRY      = 4;
  localparam int BIT_EXIT       = 3;
  localparam int BIT_ERROR      = 2;
  localparam int BIT_SLEEP_ACK  = 1;

  // Number of error status sources feeding the error flag.
  localparam int ERR_SRC_W = 4;

  // Reset values.
  localparam logic       RST_LIVE_RX    = 1'h1;
  localparam logic       RST_SAMPLED_RX = 1'h1;
  localparam logic       RST_BUSY       = 1'h0;
  localparam logic       RST_FLAG       = 1'h0;
  localparam logic       RST_SLEEP_ACK  = 1'h1;
  localparam logic [2:0] RST_IRQ_EN     = 3'h0;
  localparam logic [3:0] RST_ERR_EN     = 4'h0;
  localparam logic [31:0] RD_ZERO       = 32'h0000_0000;

  // Sleep state, one-hot.
  typedef enum logic [1:0] {
    SLP_AWAKE  = 2'h1,
    SLP_ASLEEP = 2'h2
  } ccs_sleep_e;

  // All state of the block.
  typedef struct packed {
    logic                 liveRx;
    logic                 sampledRx;
    logic                 rxBusy;
    logic                 txBusy;
    ccs_sleep_e           sleep;
    logic                 sleepAck;
    logic                 entryFlag;
    logic                 exitFlag;
    logic                 errFlag;
    logic [2:0]           irqEn;     // {entry, exit, error}
    logic [ERR_SRC_W-1:0] errEn;
    logic [31:0]          rdData;
    logic                 irq;
  } ccs_state_s;

endpackage : ccs_pkg

// File: logic/ccs_status_flags.sv
/*
  Status register logic of a CAN controller: live and sampled receive level,
  receive and transmit activity, sleep entry and exit flags, error flag, and
  a masked level interrupt. Assumes all inputs but rst_n are synchronous to clk_sys, the
  protocol engine delivers one-cycle event pulses, and a simple register port
  with reads answered one cycle later.
*/
`timescale 1ns/1ps
`default_nettype none

module ccs_status_flags (
  input  wire logic                         clk_sys,      // System clock, 50 MHz.
  input  wire logic                         rst_n,        // Asynchronous reset, active low.
  input  wire logic [7:0]                   regAddr,      // Register byte address.
  input  wire logic [31:0]                  regWrData,    // Write data.
  input  wire logic                         regWrEn,      // Write strobe.
  input  wire logic                         regRdEn,      // Read strobe.
  output logic      [31:0]                  regRdData,    // Read data, cycle after strobe.
  input  wire logic                         rxPin,        // CAN receive pin level.
  input  wire logic                         rxSampleStb,  // Bit sample point pulse.
  input  wire logic                         rxStart,      // Reception begins pulse.
  input  wire logic                         rxEnd,        // Reception ends pulse.
  input  wire logic                         txStart,      // Transmission begins pulse.
  input  wire logic                         txDone,       // Transmission completes pulse.
  input  wire logic                         sleepReq,     // Sleep requested by mode control.
  input  wire logic                         sofDetect,    // Start of frame seen pulse.
  input  wire logic [ccs_pkg::ERR_SRC_W-1:0] errSrc,      // Error status source bits.
  output logic                              sleepAck,     // Controller is asleep.
  output logic                              irq           // Status change interrupt.
);

  logic              rstMeta;
  logic              rstSync_n;
  ccs_pkg::ccs_state_s s_reg;
  ccs_pkg::ccs_state_s s_next;

  // Reset release synchroniser; the assert path stays asynchronous.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstMeta   <= 1'b0;
      rstSync_n <= 1'b0;
    end
    else
    begin
      rstMeta   <= 1'b1;
      rstSync_n <= rstMeta;
    end
  end

  // Next-state logic for every field of the block.
  always_comb
  begin
    logic       wrStatus;
    logic       goSleep;
    logic       wake;
    logic [2:0] pend;
    s_next   = s_reg;
    wrStatus = regWrEn && (regAddr == ccs_pkg::ADDR_STATUS);
    goSleep  = 1'b0;
    wake     = 1'b0;
    pend     = 3'h0;

    // Pin level follows every clock; the sampled copy only at the sample point.
    s_next.liveRx = rxPin;
    if (rxSampleStb)
    begin
      s_next.sampledRx = rxPin;
    end

    // Activity bits; a start in the same cycle as an end wins.
    if (rxStart)
    begin
      s_next.rxBusy = 1'b1;
    end
    else if (rxEnd)
    begin
      s_next.rxBusy = 1'b0;
    end
    if (txStart)
    begin
      s_next.txBusy = 1'b1;
    end
    else if (txDone)
    begin
      s_next.txBusy = 1'b0;
    end

    // Sleep is only entered with the bus quiet, so no frame is cut short.
    case (s_reg.sleep)
      ccs_pkg::SLP_AWAKE:
      begin
        if (sleepReq && !s_reg.rxBusy && !s_reg.txBusy && !rxStart && !txStart)
        begin
          s_next.sleep = ccs_pkg::SLP_ASLEEP;
          goSleep      = 1'b1;
        end
      end
      ccs_pkg::SLP_ASLEEP:
      begin
        if (sofDetect || !sleepReq)
        begin
          s_next.sleep = ccs_pkg::SLP_AWAKE;
          wake         = sofDetect;
        end
      end
      default:
      begin
        s_next.sleep = ccs_pkg::SLP_ASLEEP;
      end
    endcase
    s_next.sleepAck = (s_next.sleep == ccs_pkg::SLP_ASLEEP);

    // Software clears first; hardware sets afterwards so a coincident set wins.
    if (wrStatus)
    begin
      if (regWrData[ccs_pkg::BIT_ENTRY])
      begin
        s_next.entryFlag = 1'b0;
      end
      if (regWrData[ccs_pkg::BIT_EXIT])
      begin
        s_next.exitFlag = 1'b0;
      end
      if (regWrData[ccs_pkg::BIT_ERROR])
      begin
        s_next.errFlag = 1'b0;
      end
    end
    // Hardware clear of the entry flag when the acknowledge drops.
    if (s_reg.sleepAck && !s_next.sleepAck)
    begin
      s_next.entryFlag = 1'b0;
    end
    if (goSleep && s_reg.irqEn[2])
    begin
      s_next.entryFlag = 1'b1;
    end
    if (wake)
    begin
      s_next.exitFlag = 1'b1;
    end
    // Level sources re-set the flag each cycle they stay enabled and active.
    if (|(errSrc & s_reg.errEn))
    begin
      s_next.errFlag = 1'b1;
    end

    // Enable registers; all other bits of a write are dropped.
    if (regWrEn && (regAddr == ccs_pkg::ADDR_IRQ_EN))
    begin
      s_next.irqEn = {regWrData[ccs_pkg::BIT_ENTRY], regWrData[ccs_pkg::BIT_EXIT],
                      regWrData[ccs_pkg::BIT_ERROR]};
    end
    if (regWrEn && (regAddr == ccs_pkg::ADDR_ERR_EN))
    begin
      s_next.errEn = regWrData[ccs_pkg::ERR_SRC_W-1:0];
    end

    // Read data stands for one cycle only; reserved bits stay zero.
    s_next.rdData = ccs_pkg::RD_ZERO;
    if (regRdEn)
    begin
      case (regAddr)
        ccs_pkg::ADDR_STATUS:
        begin
          s_next.rdData[ccs_pkg::BIT_LIVE_RX]    = s_reg.liveRx;
          s_next.rdData[ccs_pkg::BIT_SAMPLED_RX] = s_reg.sampledRx;
          s_next.rdData[ccs_pkg::BIT_RX_BUSY]    = s_reg.rxBusy;
          s_next.rdData[ccs_pkg::BIT_TX_BUSY]    = s_reg.txBusy;
          s_next.rdData[ccs_pkg::BIT_ENTRY]      = s_reg.entryFlag;
          s_next.rdData[ccs_pkg::BIT_EXIT]       = s_reg.exitFlag;
          s_next.rdData[ccs_pkg::BIT_ERROR]      = s_reg.errFlag;
          s_next.rdData[ccs_pkg::BIT_SLEEP_ACK]  = s_reg.sleepAck;
        end
        ccs_pkg::ADDR_IRQ_EN:
        begin
          s_next.rdData[ccs_pkg::BIT_ENTRY] = s_reg.irqEn[2];
          s_next.rdData[ccs_pkg::BIT_EXIT]  = s_reg.irqEn[1];
          s_next.rdData[ccs_pkg::BIT_ERROR] = s_reg.irqEn[0];
        end
        ccs_pkg::ADDR_ERR_EN:
        begin
          s_next.rdData[ccs_pkg::ERR_SRC_W-1:0] = s_reg.errEn;
        end
        default:
        begin
          s_next.rdData = ccs_pkg::RD_ZERO;
        end
      endcase
    end

    // Interrupt is a level from the flag state now being registered.
    pend[2] = s_next.entryFlag;
    pend[1] = s_next.exitFlag & s_next.irqEn[1];
    pend[0] = s_next.errFlag & s_next.irqEn[0];
    s_next.irq = |pend;
  end

  // One register for all state, reset from the synchronised copy.
  always_ff @(posedge clk_sys or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      s_reg.liveRx    <= ccs_pkg::RST_LIVE_RX;
      s_reg.sampledRx <= ccs_pkg::RST_SAMPLED_RX;
      s_reg.rxBusy    <= ccs_pkg::RST_BUSY;
      s_reg.txBusy    <= ccs_pkg::RST_BUSY;
      s_reg.sleep     <= ccs_pkg::SLP_ASLEEP;
      s_reg.sleepAck  <= ccs_pkg::RST_SLEEP_ACK;
      s_reg.entryFlag <= ccs_pkg::RST_FLAG;
      s_reg.exitFlag  <= ccs_pkg::RST_FLAG;
      s_reg.errFlag   <= ccs_pkg::RST_FLAG;
      s_reg.irqEn     <= ccs_pkg::RST_IRQ_EN;
      s_reg.errEn     <= ccs_pkg::RST_ERR_EN;
      s_reg.rdData    <= ccs_pkg::RD_ZERO;
      s_reg.irq       <= ccs_pkg::RST_FLAG;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign regRdData = s_reg.rdData;
  assign sleepAck  = s_reg.sleepAck;
  assign irq       = s_reg.irq;

endmodule : ccs_status_flags

`default_nettype wire

// File: tb/ccs_status_flags_asserts.sv
/*
  Port checker for the status flag block.
  Assumes a bind onto ccs_status_flags and the single clk_sys domain.
*/
`timescale 1ns/1ps
`default_nettype none

module ccs_status_flags_asserts (
  input wire logic        clk_sys,   // System clock.
  input wire logic        rst_n,     // Reset, active low.
  input wire logic [7:0]  regAddr,   // Register address.
  input wire logic        regRdEn,   // Read strobe.
  input wire logic [31:0] regRdData, // Read data.
  input wire logic        rxPin,     // Receive pin.
  input wire logic        rxStart,   // Reception start.
  input wire logic        rxEnd,     // Reception end.
  input wire logic        txStart,   // Transmission start.
  input wire logic        txDone,    // Transmission end.
  input wire logic        sofDetect, // Start of frame.
  input wire logic        sleepAck   // Asleep.
);
  logic [1:0] upCnt;

  // The block releases two edges late, so checks wait until that is over.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      upCnt <= 2'h0;
    else if (upCnt != 2'h3)
      upCnt <= upCnt + 2'h1;
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (upCnt != 2'h3);

  // A status read; the answer shows the state from before the read edge.
  sequence s_rd_stat;
    regRdEn && regAddr == ccs_pkg::ADDR_STATUS;
  endsequence

  a_rd_idle: assert property (!regRdEn |=> regRdData == 32'h0000_0000)
    else $error("read data not zero outside a read");
  a_resvd_zero: assert property (s_rd_stat |=> (regRdData & 32'hFFFF_F0E0) == 32'h0)
    else $error("reserved status bits not zero");
  a_unmapped_zero: assert property (regRdEn && !(regAddr inside {8'h00, 8'h04, 8'h08})
    |=> regRdData == 32'h0000_0000) else $error("unmapped read not zero");
  a_live_rx: assert property (s_rd_stat |=> regRdData[11] == $past(rxPin, 2))
    else $error("live receive level wrong");
  a_rx_set: assert property (rxStart ##1 s_rd_stat |=> regRdData[9])
    else $error("receive busy not set");
  a_rx_clear: assert property (rxEnd && !rxStart ##1 s_rd_stat |=> !regRdData[9])
    else $error("receive busy not cleared");
  a_tx_set: assert property (txStart ##1 s_rd_stat |=> regRdData[8])
    else $error("transmit busy not set");
  a_tx_clear: assert property (txDone && !txStart ##1 s_rd_stat |=> !regRdData[8])
    else $error("transmit busy not cleared");
  a_sof_wake: assert property (sleepAck && sofDetect |=> !sleepAck)
    else $error("start of frame did not wake");
  a_exit_flag: assert property (sleepAck && sofDetect ##1 s_rd_stat |=> regRdData[3])
    else $error("exit flag not set on wake");
  a_entry_hwclr: assert property ($fell(sleepAck) ##1 !sleepAck ##0 s_rd_stat |=> !regRdData[4])
    else $error("entry flag kept after wake");
  a_ack_bit: assert property (s_rd_stat |=> regRdData[1] == $past(sleepAck))
    else $error("sleep ack bit differs from port");

endmodule : ccs_status_flags_asserts

bind ccs_status_flags ccs_status_flags_asserts chk_u (
  .clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr), .regRdEn(regRdEn),
  .regRdData(regRdData), .rxPin(rxPin), .rxStart(rxStart), .rxEnd(rxEnd),
  .txStart(txStart), .txDone(txDone), .sofDetect(sofDetect), .sleepAck(sleepAck)
);

`default_nettype wire

// File: tb/ccs_can_bus_model.sv
/*
  Bus side model: receive pin, sample strobe and frame event pulses.
  Assumes the bench calls sendFrame; the bus idles recessive, high.
*/
`timescale 1ns/1ps
`default_nettype none

module ccs_can_bus_model (
  input  wire logic clk_sys,     // System clock.
  output var  logic rxPin,       // Bus level.
  output var  logic rxSampleStb, // Sample point.
  output var  logic rxStart,     // Reception begins.
  output var  logic rxEnd,       // Reception ends.
  output var  logic sofDetect    // Start of frame.
);
  // Idle bus at time zero.
  initial
  begin
    {rxPin, rxSampleStb, rxStart, rxEnd, sofDetect} = 5'h10;
  end

  // Dominant start bit, then data bits first to last; gap cycles pass
  // before each sample, so a slow bus is modelled as well as a prompt one.
  task automatic sendFrame(input logic [7:0] data, input int gap);
    @(posedge clk_sys);
    {rxPin, sofDetect, rxStart} <= 3'h3;
    @(posedge clk_sys);
    {sofDetect, rxStart} <= 2'h0;
    for (int i = 7; i >= 0; i--)
    begin
      rxPin <= data[i];
      repeat (gap) @(posedge clk_sys);
      rxSampleStb <= 1'b1;
      @(posedge clk_sys);
      rxSampleStb <= 1'b0;
    end
    {rxPin, rxEnd} <= 2'h3;
    @(posedge clk_sys);
    rxEnd <= 1'b0;
  endtask : sendFrame

endmodule : ccs_can_bus_model

`default_nettype wire

// File: tb/ccs_status_flags_tb_top.sv
/*
  Self-checking bench for the status flag block over its register port.
  Assumes the bus model file and the checker bind are compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none

module ccs_status_flags_tb_top;
  logic        clk_sys, rst_n, regWrEn, regRdEn, sleepReq, txStart, txDone;
  logic        rxPin, rxSampleStb, rxStart, rxEnd, sofDetect, sleepAck, irq;
  logic [7:0]  regAddr;
  logic [31:0] regWrData, regRdData;
  logic [ccs_pkg::ERR_SRC_W-1:0] errSrc;
  int          failCount, testsRun;

  ccs_status_flags dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .rxPin(rxPin),
    .rxSampleStb(rxSampleStb), .rxStart(rxStart), .rxEnd(rxEnd), .txStart(txStart),
    .txDone(txDone), .sleepReq(sleepReq), .sofDetect(sofDetect), .errSrc(errSrc),
    .sleepAck(sleepAck), .irq(irq)
  );

  ccs_can_bus_model bus_u (
    .clk_sys(clk_sys), .rxPin(rxPin), .rxSampleStb(rxSampleStb),
    .rxStart(rxStart), .rxEnd(rxEnd), .sofDetect(sofDetect)
  );

  // Free-running 50 MHz clock.
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic completeRun();
    $display("comparisons %0d mismatches %0d", testsRun, failCount);
    if (failCount == 0 && testsRun > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : completeRun

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    testsRun++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      failCount++;
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    {regAddr, regWrData, regWrEn} <= {a, d, 1'b1};
    @(posedge clk_sys);
    regWrEn <= 1'b0;
  endtask : wr

  // Data are looked at in the one cycle where they stand; the task returns on a
  // rising edge so that callers drive their next inputs right on it.
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n,
                    input logic [31:0] m = 32'hFFFF_FFFF);
    @(posedge clk_sys);
    {regAddr, regRdEn} <= {a, 1'b1};
    @(posedge clk_sys);
    regRdEn <= 1'b0;
    #1;
    chk(n, e, regRdData & m);
    @(posedge clk_sys);
  endtask : rd

  // Pulses a transmit event for one cycle and reads the status in the next one.
  task automatic txPulse(input logic st, input logic [31:0] e, input string n);
    {txStart, txDone} <= {st, !st};
    fork
      rd(ccs_pkg::ADDR_STATUS, e, n);
      begin
        @(posedge clk_sys);
        {txStart, txDone} <= 2'h0;
      end
    join
  endtask : txPulse

  // Sleep request is held high so the block stays asleep out of reset.
  task automatic resetCheck();
    rst_n <= 1'b0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(ccs_pkg::ADDR_STATUS, 32'h0000_0C02, "reset status");
    rd(ccs_pkg::ADDR_IRQ_EN, 32'h0, "reset enables");
    wr(8'h0C, 32'hFFFF_FFFF);
    rd(8'h0C, 32'h0, "unmapped");
  endtask : resetCheck

  initial
  begin
    {rst_n, regWrEn, regRdEn, sleepReq, txStart, txDone} = 6'h04;
    {regAddr, regWrData, errSrc} = '0;
    resetCheck();
    wr(ccs_pkg::ADDR_IRQ_EN, 32'h0000_0008);
    fork
      bus_u.sendFrame(8'h5A, 2);
      begin
        // The read strobe lands one cycle after the start of frame and after the end.
        @(posedge clk_sys);
        rd(ccs_pkg::ADDR_STATUS, 32'h208, "mid frame", 32'h20A);
        chk("exit irq", 32'h1, {31'h0, irq});
        sleepReq <= 1'b0;
        wait (rxEnd);
        rd(ccs_pkg::ADDR_STATUS, 32'h808, "after frame");
      end
    join
    wr(ccs_pkg::ADDR_STATUS, 32'h0);
    rd(ccs_pkg::ADDR_STATUS, 32'h808, "write zero");
    wr(ccs_pkg::ADDR_STATUS, 32'hFFFF_FFF7);
    rd(ccs_pkg::ADDR_STATUS, 32'h808, "ro write");
    wr(ccs_pkg::ADDR_STATUS, 32'h8);
    rd(ccs_pkg::ADDR_STATUS, 32'h800, "exit clear");
    chk("irq off", 32'h0, {31'h0, irq});
    // Entry with the enable off first, then on, then a wake.
    wr(ccs_pkg::ADDR_IRQ_EN, 32'h0);
    for (int k = 0; k < 2; k++)
    begin
      sleepReq <= 1'b1;
      repeat (3) @(posedge clk_sys);
      chk("asleep", 32'h1, {31'h0, sleepAck});
      rd(ccs_pkg::ADDR_STATUS, 32'h802 | (k << 4), "entry");
      chk("entry irq", k, {31'h0, irq});
      sleepReq <= 1'b0;
      @(posedge clk_sys);
      rd(ccs_pkg::ADDR_STATUS, 32'h800, "wake clear");
      wr(ccs_pkg::ADDR_IRQ_EN, 32'h10);
    end
    rd(ccs_pkg::ADDR_STATUS, 32'h800, "entry hw clear");
    chk("irq wake", 32'h0, {31'h0, irq});
    // Entry flag cleared by software while the block stays asleep.
    sleepReq <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk("asleep again", 32'h1, {31'h0, sleepAck});
    chk("entry irq again", 32'h1, {31'h0, irq});
    wr(ccs_pkg::ADDR_STATUS, 32'h10);
    rd(ccs_pkg::ADDR_STATUS, 32'h802, "entry clear");
    chk("entry irq clear", 32'h0, {31'h0, irq});
    sleepReq <= 1'b0;
    wr(ccs_pkg::ADDR_ERR_EN, 32'h2);
    wr(ccs_pkg::ADDR_IRQ_EN, 32'h4);
    errSrc <= 4'h1;
    rd(ccs_pkg::ADDR_STATUS, 32'h800, "err masked");
    errSrc <= 4'h2;
    rd(ccs_pkg::ADDR_STATUS, 32'h804, "err set");
    chk("err irq", 32'h1, {31'h0, irq});
    errSrc <= 4'h0;
    wr(ccs_pkg::ADDR_STATUS, 32'h4);
    rd(ccs_pkg::ADDR_STATUS, 32'h800, "err clear");
    txPulse(1'b1, 32'h900, "tx busy");
    txPulse(1'b0, 32'h800, "tx done");
    sleepReq <= 1'b1;
    resetCheck();
    completeRun();
  end

  // Cuts a hang short; the tests need well under a tenth of this span.
  initial
  begin
    #100us;
    failCount++;
    completeRun();
  end

endmodule : ccs_status_flags_tb_top

`default_nettype wire
